// [rtl/ratio_numerator.v]
// Effective scale ratio numerator with default and clamp
`timescale 1ns/1ps
`default_nettype none
module ratio_numerator (
   // Clock and reset
   input wire clock_i,
   input wire rst_n_i,
   // Settings
   input wire [14:0] scale_ratio_numerator_i,
   input wire [4:0] scale_ratio_numerator_shift_i,
   input wire [17:0] enc_res_i,
   // Result
   output reg [17:0] eff_num_o,
   output reg invalid_o
);
`include "servo_limit_regs.vh"
   reg [32:0] prod;
   always @* begin
      prod = {18'h00000, scale_ratio_numerator_i} << scale_ratio_numerator_shift_i;
   end
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         eff_num_o <= `ENC_RES_DEFAULT;
         invalid_o <= 1'b0;
      end else if (scale_ratio_numerator_i == 15'h0000) begin
         eff_num_o <= enc_res_i;
         invalid_o <= 1'b0;
      end else if (prod > {15'h0000, `NUM_LIMIT}) begin
         eff_num_o <= `NUM_LIMIT;
         invalid_o <= 1'b1;
      end else begin
         eff_num_o <= prod[17:0];
         invalid_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [rtl/servo_limit_and_scale_ratio.v]
// Overload, over-speed thresholds and scale ratio with Avalon-MM registers
// How it works
// - Overload setting 0..500, zero means 115
// - Effective overload never above 115 percent
// - Over-speed setting 0..20000, zero means 1.2x
// - Effective over-speed at most 1.2x max
// - Speed detection tolerance 3 or 36 r/min
// - Ratio numerator times two to shift
// - Numerator zero uses encoder resolution
// - Numerator after shift limited to 131072
// - Denominator 1..32767, default 10000
//
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module servo_limit_and_scale_ratio (
   // Clock and reset
   input wire clock_i,
   input wire rst_n_i,
   // Avalon-MM slave
   input wire [3:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   output reg [31:0] avs_readdata_o,
   output reg avs_waitrequest_o,
   // Feedback
   input wire [15:0] meas_load_i,
   input wire [15:0] meas_speed_i,
   input wire meas_valid_i,
   // Results
   output reg [15:0] eff_overload_o,
   output reg [15:0] eff_overspeed_o,
   output reg [17:0] eff_numerator_o,
   output reg [14:0] eff_denominator_o,
   output reg fault_o,
   output reg irq_o
);
`include "servo_limit_regs.vh"
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_ACK = 3'b010;
   localparam [2:0] ST_DONE = 3'b100;

   reg [2:0] state_r;
   reg [15:0] overload_level_setting_r;
   reg [15:0] overspeed_level_setting_r;
   reg [14:0] scale_ratio_numerator_r;
   reg [4:0] scale_ratio_numerator_shift_r;
   reg [14:0] scale_ratio_denominator_r;
   reg [17:0] enc_res_r;
   reg [15:0] max_speed_r;
   reg enc_inc_r;
   reg [15:0] load_r;
   reg [15:0] speed_r;
   reg [1:0] irq_status_r;
   reg [1:0] irq_enable_r;
   reg [1:0] irq_clear_nxt;
   reg [15:0] ovl_nxt;
   reg [15:0] ovs_nxt;
   reg [15:0] speed_limit;
   reg [15:0] tol;
   reg over_load;
   reg over_speed;
   reg [31:0] rd_nxt;
   reg num_invalid_r;
   wire [17:0] eff_num;
   wire num_invalid;
   wire wr_go;

   // Clamp a setting into [lo, hi]
   function [15:0] clamp16;
      input [15:0] v;
      input [15:0] lo;
      input [15:0] hi;
      begin
         if (v < lo) begin
            clamp16 = lo;
         end else if (v > hi) begin
            clamp16 = hi;
         end else begin
            clamp16 = v;
         end
      end
   endfunction

   // Strictly above threshold plus margin; one bit wider so the sum cannot wrap
   function exceeds;
      input [15:0] val;
      input [15:0] thr;
      input [15:0] margin;
      begin
         exceeds = {1'b0, val} > ({1'b0, thr} + {1'b0, margin});
      end
   endfunction

   // 1.2x maximum speed as top + top/5, truncated; top stays below 2^15
   function [15:0] speed_ceiling;
      input [15:0] top;
      begin
         speed_ceiling = top + top / 16'd5;
      end
   endfunction

   ratio_numerator u_num (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .scale_ratio_numerator_i(scale_ratio_numerator_r),
      .scale_ratio_numerator_shift_i(scale_ratio_numerator_shift_r),
      .enc_res_i(enc_res_r),
      .eff_num_o(eff_num),
      .invalid_o(num_invalid)
   );

   // One wait cycle per access; write lands on the ack edge
   assign wr_go = (state_r == ST_ACK) && avs_write_i;

   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         state_r <= ST_IDLE;
         avs_waitrequest_o <= 1'b1;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (avs_read_i || avs_write_i) begin
                  state_r <= ST_ACK;
                  avs_waitrequest_o <= 1'b0;
               end
            end
            ST_ACK: begin
               state_r <= ST_DONE;
               avs_waitrequest_o <= 1'b1;
            end
            ST_DONE: begin
               state_r <= ST_IDLE;
            end
            default: begin
               state_r <= ST_IDLE;
               avs_waitrequest_o <= 1'b1;
            end
         endcase
      end
   end

   // Effective thresholds
   always @* begin
      if (overload_level_setting_r == 16'h0000) begin
         ovl_nxt = `OVERLOAD_DEFAULT;
      end else if (overload_level_setting_r > `OVERLOAD_DEFAULT) begin
         ovl_nxt = `OVERLOAD_DEFAULT;
      end else begin
         ovl_nxt = overload_level_setting_r;
      end
      speed_limit = speed_ceiling(max_speed_r);
      if (overspeed_level_setting_r == 16'h0000) begin
         ovs_nxt = speed_limit;
      end else begin
         ovs_nxt = clamp16(overspeed_level_setting_r, 16'h0000, speed_limit);
      end
      tol = enc_inc_r ? `TOL_INC : `TOL_ABS;
      over_load = exceeds(load_r, eff_overload_o, 16'h0000);
      // Tolerance band: fire only past threshold plus detection error
      over_speed = exceeds(speed_r, eff_overspeed_o, tol);
   end

   always @* begin
      irq_clear_nxt = 2'b00;
      if (wr_go && avs_address_i == `REG_IRQ_CLEAR) begin
         irq_clear_nxt = avs_writedata_i[1:0];
      end
      case (avs_address_i)
         `REG_OVERLOAD_SET: rd_nxt = {16'h0000, overload_level_setting_r};
         `REG_OVERSPEED_SET: rd_nxt = {16'h0000, overspeed_level_setting_r};
         `REG_RATIO_NUM: rd_nxt = {17'h00000, scale_ratio_numerator_r};
         `REG_RATIO_SHIFT: rd_nxt = {27'h0000000, scale_ratio_numerator_shift_r};
         `REG_RATIO_DEN: rd_nxt = {17'h00000, scale_ratio_denominator_r};
         `REG_MOTOR_CFG: rd_nxt = {enc_inc_r, 13'h0000, enc_res_r};
         `REG_MAX_SPEED: rd_nxt = {16'h0000, max_speed_r};
         `REG_MEAS_LOAD: rd_nxt = {16'h0000, load_r};
         `REG_MEAS_SPEED: rd_nxt = {16'h0000, speed_r};
         `REG_EFF_OVERLOAD: rd_nxt = {16'h0000, eff_overload_o};
         `REG_EFF_OVERSPEED: rd_nxt = {16'h0000, eff_overspeed_o};
         `REG_EFF_NUM: rd_nxt = {13'h0000, num_invalid_r, eff_numerator_o};
         `REG_IRQ_STATUS: rd_nxt = {30'h00000000, irq_status_r};
         `REG_IRQ_ENABLE: rd_nxt = {30'h00000000, irq_enable_r};
         default: rd_nxt = 32'h00000000;
      endcase
   end

   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         overload_level_setting_r <= 16'h0000;
         overspeed_level_setting_r <= 16'h0000;
         scale_ratio_numerator_r <= 15'h0000;
         scale_ratio_numerator_shift_r <= 5'h00;
         scale_ratio_denominator_r <= `DEN_DEFAULT;
         enc_res_r <= `ENC_RES_DEFAULT;
         max_speed_r <= `MAX_SPEED_DEFAULT;
         enc_inc_r <= 1'b0;
         irq_enable_r <= 2'b00;
         avs_readdata_o <= 32'h00000000;
      end else begin
         if (state_r == ST_IDLE && avs_read_i) begin
            avs_readdata_o <= rd_nxt;
         end
         if (wr_go) begin
            case (avs_address_i)
               `REG_OVERLOAD_SET:
                  overload_level_setting_r <= clamp16(avs_writedata_i[15:0], 16'h0000,
                     `OVERLOAD_MAX);
               `REG_OVERSPEED_SET:
                  overspeed_level_setting_r <= clamp16(avs_writedata_i[15:0], 16'h0000,
                     `OVERSPEED_MAX);
               `REG_RATIO_NUM: scale_ratio_numerator_r <= avs_writedata_i[14:0];
               `REG_RATIO_SHIFT: begin
                  if (avs_writedata_i[4:0] > `SHIFT_MAX) begin
                     scale_ratio_numerator_shift_r <= `SHIFT_MAX;
                  end else begin
                     scale_ratio_numerator_shift_r <= avs_writedata_i[4:0];
                  end
               end
               `REG_RATIO_DEN: begin
                  if (avs_writedata_i[14:0] < `DEN_MIN) begin
                     scale_ratio_denominator_r <= `DEN_MIN;
                  end else begin
                     scale_ratio_denominator_r <= avs_writedata_i[14:0];
                  end
               end
               `REG_MOTOR_CFG: begin
                  enc_res_r <= avs_writedata_i[17:0];
                  enc_inc_r <= avs_writedata_i[31];
               end
               // Kept below 2^15 so the 1.2x ceiling still fits 16 bits
               `REG_MAX_SPEED: max_speed_r <= {1'b0, avs_writedata_i[14:0]};
               `REG_IRQ_ENABLE: irq_enable_r <= avs_writedata_i[1:0];
               default: begin
               end
            endcase
         end
      end
   end

   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         load_r <= 16'h0000;
         speed_r <= 16'h0000;
         eff_overload_o <= `OVERLOAD_DEFAULT;
         eff_overspeed_o <= speed_ceiling(`MAX_SPEED_DEFAULT);
         eff_numerator_o <= `ENC_RES_DEFAULT;
         num_invalid_r <= 1'b0;
         eff_denominator_o <= `DEN_DEFAULT;
         fault_o <= 1'b0;
         irq_status_r <= 2'b00;
         irq_o <= 1'b0;
      end else begin
         if (meas_valid_i) begin
            load_r <= meas_load_i;
            speed_r <= meas_speed_i;
         end
         eff_overload_o <= ovl_nxt;
         eff_overspeed_o <= ovs_nxt;
         eff_numerator_o <= eff_num;
         // Flag aligned with the numerator it qualifies
         num_invalid_r <= num_invalid;
         eff_denominator_o <= scale_ratio_denominator_r;
         fault_o <= over_load || over_speed;
         // Set wins over clear in the same cycle
         irq_status_r <= (irq_status_r & ~irq_clear_nxt) | {over_speed, over_load};
         irq_o <= |(((irq_status_r & ~irq_clear_nxt) | {over_speed, over_load}) & irq_enable_r);
      end
   end
endmodule
`default_nettype wire

// [rtl/servo_limit_regs.vh]
// Register offsets, field positions, reset values and limits of the servo limit block
`ifndef SERVO_LIMIT_REGS_VH
`define SERVO_LIMIT_REGS_VH
`define REG_OVERLOAD_SET 4'h0
`define REG_OVERSPEED_SET 4'h1
`define REG_RATIO_NUM 4'h2
`define REG_RATIO_SHIFT 4'h3
`define REG_RATIO_DEN 4'h4
`define REG_MOTOR_CFG 4'h5
`define REG_MEAS_LOAD 4'h6
`define REG_MEAS_SPEED 4'h7
`define REG_EFF_OVERLOAD 4'h8
`define REG_EFF_OVERSPEED 4'h9
`define REG_EFF_NUM 4'hA
`define REG_IRQ_STATUS 4'hB
`define REG_IRQ_CLEAR 4'hC
`define REG_IRQ_ENABLE 4'hD
`define REG_MAX_SPEED 4'hE
`define OVERLOAD_MAX 16'h01F4
`define OVERLOAD_DEFAULT 16'h0073
`define OVERSPEED_MAX 16'h4E20
`define NUM_MAX 15'h7FFF
`define SHIFT_MAX 5'h11
`define NUM_LIMIT 18'h20000
`define DEN_DEFAULT 15'h2710
`define DEN_MIN 15'h0001
`define ENC_RES_DEFAULT 18'h20000
`define MAX_SPEED_DEFAULT 16'h1770
`define TOL_ABS 16'h0003
`define TOL_INC 16'h0024
`define CFG_ENC_INC_BIT 0
`define IRQ_OVERLOAD_BIT 0
`define IRQ_OVERSPEED_BIT 1
`endif

// [testbench/feedback_model.sv]
// Load and speed feedback source standing in for encoder and scale
`timescale 1ns/1ps
`default_nettype none
module feedback_model (
   input wire logic clock_i, go_i,
   input wire logic [15:0] load_i, speed_i,
   output logic [15:0] meas_load_o, meas_speed_o,
   output logic meas_valid_o
);
   initial begin
      meas_load_o = 16'h0000;
      meas_speed_o = 16'h0000;
      meas_valid_o = 1'b0;
   end
   // Lines toggle between samples so a stale value never reads as fresh
   always @(posedge clock_i) begin
      meas_valid_o <= go_i;
      meas_load_o <= go_i ? load_i : ~meas_load_o;
      meas_speed_o <= go_i ? speed_i : ~meas_speed_o;
   end
endmodule
`default_nettype wire

// [testbench/servo_limit_sva.sv]
// Assertion checker for the servo limit block ports
`timescale 1ns/1ps
`default_nettype none
module servo_limit_sva (
   // Clock, reset and bus handshake
   input wire logic clock_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o,
   // Feedback
   input wire logic [15:0] meas_load_i, meas_speed_i,
   input wire logic meas_valid_i,
   // Results
   input wire logic [15:0] eff_overload_o, eff_overspeed_o,
   input wire logic [17:0] eff_numerator_o,
   input wire logic [14:0] eff_denominator_o,
   input wire logic fault_o, irq_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   ack_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o [*2])
      else $error("wait low too long");
   ack_cause_a: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
      else $error("ack without request");
   ovl_zero_a: assert property (eff_overload_o != 16'h0000)
      else $error("overload level zero");
   ovl_cap_a: assert property (eff_overload_o <= 16'h0073)
      else $error("overload level above cap");
   num_cap_a: assert property (eff_numerator_o <= 18'h20000)
      else $error("numerator above limit");
   den_min_a: assert property (eff_denominator_o != 15'h0000)
      else $error("denominator zero");
   fault_set_a: assert property (meas_valid_i && meas_load_i > eff_overload_o |-> ##2 fault_o)
      else $error("overload fault missed");
   fault_clr_a: assert property (meas_valid_i && meas_load_i <= eff_overload_o &&
      meas_speed_i <= eff_overspeed_o |-> ##2 !fault_o) else $error("false fault");
   // Reset must win even while disabled assertions sleep
   rst_quiet_a: assert property (disable iff (1'b0)
      !rst_n_i |=> avs_waitrequest_o && !fault_o && !irq_o) else $error("reset state wrong");
   cover property ($rose(fault_o));
   cover property ($rose(irq_o));
   cover property (!avs_waitrequest_o && avs_read_i);
endmodule
bind servo_limit_and_scale_ratio servo_limit_sva chk_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
   .meas_load_i(meas_load_i), .meas_speed_i(meas_speed_i), .meas_valid_i(meas_valid_i),
   .eff_overload_o(eff_overload_o), .eff_overspeed_o(eff_overspeed_o),
   .eff_numerator_o(eff_numerator_o), .eff_denominator_o(eff_denominator_o),
   .fault_o(fault_o), .irq_o(irq_o));
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the servo limit block
`timescale 1ns/1ps
`default_nettype none
`include "servo_limit_regs.vh"
module tb;
   logic clock_i = 1'b0, rst_n_i = 1'b0, rd = 1'b0, wr = 1'b0, go = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wd = 32'h0, q, rdd, s, h, n, t;
   logic [15:0] ld = 16'h0, sp = 16'h0, ml, ms, eol, eos;
   logic mv, wq, flt, irq;
   logic [17:0] enm;
   logic [14:0] edn;
   int errors = 0, comparisons = 0, i;
   int oc[4] = '{0, 116, 500, 1}, sc[4] = '{0, 7201, 20000, 1};
   int nc[4] = '{0, 1, 3, 32767}, tc[4] = '{0, 17, 16, 2};
   initial forever #5 clock_i = ~clock_i;
   feedback_model fb (.clock_i(clock_i), .go_i(go), .load_i(ld), .speed_i(sp),
      .meas_load_o(ml), .meas_speed_o(ms), .meas_valid_o(mv));
   servo_limit_and_scale_ratio dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdd),
      .avs_waitrequest_o(wq), .meas_load_i(ml), .meas_speed_i(ms), .meas_valid_i(mv),
      .eff_overload_o(eol), .eff_overspeed_o(eos), .eff_numerator_o(enm),
      .eff_denominator_o(edn), .fault_o(flt), .irq_o(irq));
   task final_report;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [31:0] e, input logic [31:0] g, input string nm);
      comparisons++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         errors++;
      end
   endtask
   // Leading edge keeps strobes from being reassigned in one step
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clock_i);
      adr <= a; wd <= d; wr <= w; rd <= !w;
      do begin @(posedge clock_i); k++; end while (wq !== 1'b0 && k < 40);
      q = rdd;
      wr <= 1'b0;
      rd <= 1'b0;
      if (wq !== 1'b0) begin errors++; final_report; end
   endtask
   task feed(input logic [15:0] l, input logic [15:0] v);
      ld <= l; sp <= v; go <= 1'b1;
      @(posedge clock_i);
      go <= 1'b0;
      repeat (3) @(posedge clock_i);
   endtask
   function automatic [31:0] e_ol(input [31:0] v);
      return (v == 0 || v > 115) ? 115 : v;
   endfunction
   function automatic [31:0] e_os(input [31:0] v);
      int lim;
      lim = `MAX_SPEED_DEFAULT + `MAX_SPEED_DEFAULT / 5;
      return (v == 0 || v > lim) ? lim : v;
   endfunction
   function automatic [31:0] e_nm(input [31:0] v, input [31:0] sh);
      if (v == 0) return `ENC_RES_DEFAULT;
      return ((v << sh) > 32'h20000) ? 32'h20000 : v << sh;
   endfunction
   initial begin
      s = $urandom(32'hF15B);
      repeat (16) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      chk(32'h73, eol, "overload after reset");
      chk(`DEN_DEFAULT, edn, "denominator after reset");
      chk(`ENC_RES_DEFAULT, enm, "numerator after reset");
      for (i = 0; i < 12; i++) begin
         s = (i < 4) ? oc[i] : $urandom % 600;
         h = (i < 4) ? sc[i] : $urandom % 25000;
         bus(1'b1, `REG_OVERLOAD_SET, s);
         bus(1'b1, `REG_OVERSPEED_SET, h);
         bus(1'b0, `REG_EFF_OVERLOAD, 32'h0);
         chk(e_ol(s), q, "overload read");
         chk(e_ol(s), eol, "overload port");
         chk(e_os(h), eos, "overspeed port");
      end
      for (i = 0; i < 12; i++) begin
         n = (i < 4) ? nc[i] : $urandom % 32768;
         t = (i < 4) ? tc[i] : $urandom % 18;
         bus(1'b1, `REG_RATIO_NUM, n);
         bus(1'b1, `REG_RATIO_SHIFT, t);
         repeat (2) @(posedge clock_i);
         bus(1'b0, `REG_EFF_NUM, 32'h0);
         chk(e_nm(n, t), enm, "numerator");
         chk(e_nm(n, t) | ((n != 0 && (n << t) > 32'h20000) ? 32'h40000 : 32'h0), q,
            "numerator read");
      end
      bus(1'b1, `REG_RATIO_DEN, 32'h7FFF);
      bus(1'b0, 4'hF, 32'h0);
      chk(32'h0, q, "unmapped read");
      chk(32'h7FFF, edn, "denominator");
      bus(1'b1, `REG_RATIO_DEN, 32'h0);
      bus(1'b0, `REG_RATIO_DEN, 32'h0);
      chk(`DEN_MIN, q, "denominator clamp read");
      chk(`DEN_MIN, edn, "denominator clamp");
      bus(1'b1, `REG_RATIO_SHIFT, 32'h1F);
      bus(1'b0, `REG_RATIO_SHIFT, 32'h0);
      chk(`SHIFT_MAX, q, "shift clamp");
      bus(1'b1, `REG_OVERLOAD_SET, 32'h0);
      bus(1'b1, `REG_OVERSPEED_SET, 32'h0);
      bus(1'b1, `REG_IRQ_ENABLE, 32'h3);
      feed(16'h0074, 16'h0000);
      chk(1, flt, "overload fault");
      chk(1, irq, "irq on");
      feed(16'h0073, 16'h1C23);
      chk(0, flt, "speed in tolerance");
      feed(16'h0000, 16'h1C24);
      chk(1, flt, "overspeed fault");
      bus(1'b0, `REG_IRQ_STATUS, 32'h0);
      chk(32'h3, q, "sticky status");
      bus(1'b1, `REG_IRQ_ENABLE, 32'h0);
      bus(1'b0, `REG_IRQ_STATUS, 32'h0);
      chk(0, irq, "irq masked");
      feed(16'h0000, 16'h0000);
      bus(1'b1, `REG_IRQ_CLEAR, 32'h3);
      bus(1'b1, `REG_IRQ_ENABLE, 32'h3);
      bus(1'b0, `REG_IRQ_STATUS, 32'h0);
      chk(32'h0, q, "status cleared");
      chk(0, irq, "irq cleared");
      bus(1'b1, `REG_MOTOR_CFG, 32'h80010000);
      bus(1'b1, `REG_MAX_SPEED, 32'h1388);
      bus(1'b1, `REG_RATIO_NUM, 32'h0);
      bus(1'b0, `REG_EFF_OVERSPEED, 32'h0);
      chk(32'h1770, q, "overspeed scaled");
      chk(32'h10000, enm, "numerator from encoder");
      feed(16'h0000, 16'h1794);
      chk(0, flt, "speed in wide tolerance");
      feed(16'h0000, 16'h1795);
      chk(1, flt, "overspeed wide fault");
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      chk(`ENC_RES_DEFAULT, enm, "numerator after second reset");
      chk(e_os(0), eos, "overspeed after second reset");
      chk(`DEN_DEFAULT, edn, "denominator after second reset");
      chk(0, flt, "fault after second reset");
      chk(0, irq, "irq after second reset");
      final_report;
   end
endmodule
`default_nettype wire
